/* File: inc/fpb_pkg.sv */
// package of constants for the flash page and board control registers
package fpb_pkg;
    // ----------------------------------------------------------------
    // register offsets in host i/o space
    // ----------------------------------------------------------------
    localparam logic [15:0] PAGE_SELECT_ADDR = 16'h028E;
    localparam logic [15:0] PAGE_SIZE_ADDR = 16'h028F;
    localparam logic [15:0] LAMP_ADDR = 16'h0340;
    localparam logic [7:0] GOUT_OFFSET = 8'h34;
    // ----------------------------------------------------------------
    // general output register bit positions
    // ----------------------------------------------------------------
    localparam int SECOND_ETH_BIT = 27;
    localparam int FIRST_ETH_BIT = 28;
    localparam int SECOND_SER_BIT = 29;
    localparam int FIRST_SER_BIT = 30;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
    localparam logic [7:0] PAGE_SIZE_RST = 8'h03;
    localparam logic [7:0] LAMP_RST = 8'h00;
    localparam logic [31:0] GOUT_RST = 32'h1800_0000;
    // ----------------------------------------------------------------
    // page size codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SIZE_8K = 2'h0;
    localparam logic [1:0] SIZE_32K = 2'h1;
    localparam logic [1:0] SIZE_64K = 2'h2;
    localparam logic [1:0] SIZE_16K = 2'h3;
    // ----------------------------------------------------------------
    // memory windows, 20-bit host addresses
    // ----------------------------------------------------------------
    localparam logic [19:0] WIN_END = 20'hDFFFF;
    localparam logic [19:0] WIN8_BASE = 20'hDE000;
    localparam logic [19:0] WIN16_BASE = 20'hDC000;
    localparam logic [19:0] WIN32_BASE = 20'hD8000;
    localparam logic [19:0] WIN64_BASE = 20'hD0000;
    localparam logic [19:0] ONB_BASE = 20'hCC000;
    localparam logic [19:0] ONB_END = 20'hCFFFF;
endpackage : fpb_pkg

/* File: verilog/fpb_rw_reg.sv */
// one read/write register with reset value, loaded on a host write
`timescale 1ns/100ps
module fpb_rw_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // write side
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // stored value
    output logic [WIDTH-1:0] value_q
);
    logic [WIDTH-1:0] value_d;

    // next value: take write data on the write cycle
    always_comb begin
        value_d = wr_en ? wr_data : value_q;
    end

    // register stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end
endmodule : fpb_rw_reg

/* File: verilog/fpb_regs.sv */
// flash page select, page size, lamp and port steering register group
`timescale 1ns/100ps
module fpb_regs #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // host i/o cycle
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [31:0] io_wdata,
    output logic [31:0] io_rdata,
    output logic io_hit,
    // power management base for the general output register
    input wire logic [ADDR_W-1:0] power_mgmt_io_base,
    // host memory cycle
    input wire logic [19:0] mem_addr,
    output logic socket_win_sel,
    output logic onboard_win_sel,
    // flash upper address lines a13..a21
    output logic [8:0] flash_hi_addr,
    // front panel lamp and port steering
    output logic lamp_on,
    output logic second_ethernet_steer,
    output logic first_ethernet_steer,
    output logic second_serial_steer,
    output logic first_serial_steer
);
    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic sel_page;
    logic sel_size;
    logic sel_lamp;
    logic sel_gout;
    logic [ADDR_W-1:0] gout_addr;

    assign gout_addr = power_mgmt_io_base + ADDR_W'(fpb_pkg::GOUT_OFFSET);
    assign sel_page = (io_addr == ADDR_W'(fpb_pkg::PAGE_SELECT_ADDR));
    assign sel_size = (io_addr == ADDR_W'(fpb_pkg::PAGE_SIZE_ADDR));
    assign sel_lamp = (io_addr == ADDR_W'(fpb_pkg::LAMP_ADDR));
    assign sel_gout = (io_addr == gout_addr);
    assign io_hit = (io_rd | io_wr) & (sel_page | sel_size | sel_lamp | sel_gout);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] page_select_q;
    logic [7:0] page_size_q;
    logic [7:0] lamp_q;
    logic [31:0] gout_q;

    // shared page select, reset zero
    fpb_rw_reg #(.WIDTH(8), .RESET_VAL(fpb_pkg::PAGE_SELECT_RST)) u_page (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(io_wr & sel_page),
        .wr_data(io_wdata[7:0]),
        .value_q(page_select_q)
    );

    // socket page size, reset code 3
    fpb_rw_reg #(.WIDTH(8), .RESET_VAL(fpb_pkg::PAGE_SIZE_RST)) u_size (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(io_wr & sel_size),
        .wr_data(io_wdata[7:0]),
        .value_q(page_size_q)
    );

    // front lamp, reset off
    fpb_rw_reg #(.WIDTH(8), .RESET_VAL(fpb_pkg::LAMP_RST)) u_lamp (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(io_wr & sel_lamp),
        .wr_data(io_wdata[7:0]),
        .value_q(lamp_q)
    );

    // general output register, ethernet steering bits reset to one, serial steering bits to zero
    fpb_rw_reg #(.WIDTH(32), .RESET_VAL(fpb_pkg::GOUT_RST)) u_gout (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(io_wr & sel_gout),
        .wr_data(io_wdata),
        .value_q(gout_q)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // unmapped reads return zero
    always_comb begin
        io_rdata = 32'h0000_0000;
        if (io_rd) begin
            if (sel_page) begin
                io_rdata = {24'h000000, page_select_q};
            end else if (sel_size) begin
                io_rdata = {24'h000000, page_size_q};
            end else if (sel_lamp) begin
                io_rdata = {24'h000000, lamp_q};
            end else if (sel_gout) begin
                io_rdata = gout_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // lamp lit while register holds one
    assign lamp_on = (lamp_q == 8'h01);

    // ethernet: 1 front; serial: 0 front
    assign second_ethernet_steer = gout_q[fpb_pkg::SECOND_ETH_BIT];
    assign first_ethernet_steer = gout_q[fpb_pkg::FIRST_ETH_BIT];
    assign second_serial_steer = ~gout_q[fpb_pkg::SECOND_SER_BIT];
    assign first_serial_steer = ~gout_q[fpb_pkg::FIRST_SER_BIT];

    // ----------------------------------------------------------------
    // memory windows
    // ----------------------------------------------------------------
    logic [19:0] win_base;

    // window base from the size code
    always_comb begin
        case (page_size_q[1:0])
            fpb_pkg::SIZE_8K: win_base = fpb_pkg::WIN8_BASE;
            fpb_pkg::SIZE_32K: win_base = fpb_pkg::WIN32_BASE;
            fpb_pkg::SIZE_64K: win_base = fpb_pkg::WIN64_BASE;
            fpb_pkg::SIZE_16K: win_base = fpb_pkg::WIN16_BASE;
            default: win_base = fpb_pkg::WIN16_BASE;
        endcase
    end

    assign socket_win_sel = (mem_addr >= win_base) && (mem_addr <= fpb_pkg::WIN_END);
    assign onboard_win_sel = (mem_addr >= fpb_pkg::ONB_BASE) && (mem_addr <= fpb_pkg::ONB_END);

    // ----------------------------------------------------------------
    // page select onto flash a13..a21
    // ----------------------------------------------------------------
    // onboard flash always uses 16 kB mapping
    always_comb begin
        flash_hi_addr = 9'h000;
        if (onboard_win_sel) begin
            flash_hi_addr = {page_select_q, 1'b0};
        end else begin
            case (page_size_q[1:0])
                fpb_pkg::SIZE_8K: flash_hi_addr = {3'h0, page_select_q[5:0]};
                fpb_pkg::SIZE_16K: flash_hi_addr = {page_select_q, 1'b0};
                fpb_pkg::SIZE_32K: flash_hi_addr = {3'h0, page_select_q[3:0], 2'h0};
                fpb_pkg::SIZE_64K: flash_hi_addr = {3'h0, page_select_q[2:0], 3'h0};
                default: flash_hi_addr = 9'h000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    front_after_reset_a: assert property (@(posedge sys_clk) $fell(rst) |->
        (second_ethernet_steer && first_ethernet_steer && second_serial_steer && first_serial_steer))
        else $error("ports not at front after reset");
    lamp_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        io_wr && sel_lamp |=> lamp_on == ($past(io_wdata[7:0]) == 8'h01))
        else $error("lamp does not follow write");
    page_readback_a: assert property (@(posedge sys_clk) disable iff (rst)
        io_wr && sel_page ##1 io_rd && sel_page && !io_wr |-> io_rdata[7:0] == $past(io_wdata[7:0]))
        else $error("page select readback wrong");
    map_8k_a: assert property (@(posedge sys_clk) disable iff (rst)
        !onboard_win_sel && page_size_q[1:0] == 2'h0 |-> flash_hi_addr[5:0] == page_select_q[5:0])
        else $error("8k mapping wrong");
    map_16k_a: assert property (@(posedge sys_clk) disable iff (rst)
        page_size_q[1:0] == 2'h3 |-> flash_hi_addr[8:1] == page_select_q)
        else $error("16k mapping wrong");
    map_64k_a: assert property (@(posedge sys_clk) disable iff (rst)
        !onboard_win_sel && page_size_q[1:0] == 2'h2 |-> flash_hi_addr == {3'h0, page_select_q[2:0], 3'h0})
        else $error("64k mapping wrong");
    win_32k_a: assert property (@(posedge sys_clk) disable iff (rst)
        page_size_q[1:0] == 2'h1 && mem_addr == 20'hD7FFF |-> !socket_win_sel)
        else $error("32k window too low");
    win_8k_a: assert property (@(posedge sys_clk) disable iff (rst)
        page_size_q[1:0] == 2'h0 && mem_addr == 20'hDE000 |-> socket_win_sel)
        else $error("8k window missing");
    onboard_win_a: assert property (@(posedge sys_clk)
        mem_addr == 20'hCBFFF |-> !onboard_win_sel)
        else $error("onboard window too low");
    serial_pol_a: assert property (@(posedge sys_clk) disable iff (rst)
        io_wr && sel_gout |=> first_serial_steer == !$past(io_wdata[30]))
        else $error("serial steering polarity wrong");
    map_32k_a: assert property (@(posedge sys_clk) disable iff (rst)
        !onboard_win_sel && page_size_q[1:0] == 2'h1 |-> flash_hi_addr[5:2] == page_select_q[3:0])
        else $error("32k mapping wrong");
    eth_steer_a: assert property (@(posedge sys_clk) disable iff (rst)
        io_wr && sel_gout |=> first_ethernet_steer == $past(io_wdata[28]))
        else $error("ethernet steering polarity wrong");
    size_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        io_wr && sel_size |=> page_size_q == $past(io_wdata[7:0]))
        else $error("page size write lost");
    unmapped_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        io_rd && !io_hit |-> io_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : fpb_regs

/* File: tb/tb.sv */
// self-checking bench for the flash page and board control register group
`timescale 1ns/100ps
module tb;
    // ----------------------------------------------------------------
    // clock, reset and design connections
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [31:0] io_wdata = 32'h0000_0000;
    logic [31:0] io_rdata;
    logic io_hit;
    logic [15:0] power_mgmt_io_base = 16'h1000;
    logic [19:0] mem_addr = 20'h00000;
    logic socket_win_sel;
    logic onboard_win_sel;
    logic [8:0] flash_hi_addr;
    logic lamp_on;
    logic second_ethernet_steer;
    logic first_ethernet_steer;
    logic second_serial_steer;
    logic first_serial_steer;
    logic [15:0] gout_addr;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    // per size code: window base, used select bits and their lowest line
    logic [19:0] win_base [0:3] = '{20'hDE000, 20'hD8000, 20'hD0000, 20'hDC000};
    logic [7:0] sel_mask [0:3] = '{8'h3F, 8'h0F, 8'h07, 8'hFF};
    int sel_shift [0:3] = '{0, 2, 3, 1};

    assign gout_addr = power_mgmt_io_base + {8'h00, fpb_pkg::GOUT_OFFSET};

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    fpb_regs uut (
        .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .power_mgmt_io_base(power_mgmt_io_base), .mem_addr(mem_addr),
        .socket_win_sel(socket_win_sel), .onboard_win_sel(onboard_win_sel),
        .flash_hi_addr(flash_hi_addr), .lamp_on(lamp_on),
        .second_ethernet_steer(second_ethernet_steer), .first_ethernet_steer(first_ethernet_steer),
        .second_serial_steer(second_serial_steer), .first_serial_steer(first_serial_steer)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report;
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // write strobe held through one rising edge, left up for back-to-back use
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_rd = 1'b0;
        io_wr = 1'b1;
        @(posedge sys_clk);
    endtask : wr

    // read data and hit flag sampled at the first rising edge of the strobe, which is left up after it
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic hit);
        @(negedge sys_clk);
        io_addr = a;
        io_wr = 1'b0;
        io_rd = 1'b1;
        @(posedge sys_clk);
        chk(io_rdata, exp);
        chk({31'h0, io_hit}, {31'h0, hit});
    endtask : rd

    task automatic idle;
        @(negedge sys_clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask : idle

    // lamp, ethernet two/one, serial two/one
    task automatic outs(input logic [4:0] exp);
        chk({27'h0, lamp_on, second_ethernet_steer, first_ethernet_steer, second_serial_steer,
             first_serial_steer}, {27'h0, exp});
    endtask : outs

    // socket expectation given, onboard window worked out here
    task automatic mchk(input logic [19:0] a, input logic s);
        logic o;
        o = (a >= fpb_pkg::ONB_BASE) && (a <= fpb_pkg::ONB_END);
        @(negedge sys_clk);
        mem_addr = a;
        #1;
        chk({30'h0, socket_win_sel, onboard_win_sel}, {30'h0, s, o});
    endtask : mchk

    task automatic reset_vals;
        rd(fpb_pkg::PAGE_SELECT_ADDR, 32'h0000_0000, 1'b1);
        rd(fpb_pkg::PAGE_SIZE_ADDR, 32'h0000_0003, 1'b1);
        rd(fpb_pkg::LAMP_ADDR, 32'h0000_0000, 1'b1);
        rd(gout_addr, 32'h1800_0000, 1'b1);
        idle();
        outs(5'h0F);
    endtask : reset_vals

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [8:0] m;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        reset_vals();
        // lamp lit only by exactly one
        wr(fpb_pkg::LAMP_ADDR, 32'h0000_0001);
        idle();
        outs(5'h1F);
        wr(fpb_pkg::LAMP_ADDR, 32'h0000_0002);
        rd(fpb_pkg::LAMP_ADDR, 32'h0000_0002, 1'b1);
        idle();
        outs(5'h0F);
        // unmapped place is ignored and reads zero
        wr(16'h0341, 32'h0000_0001);
        rd(16'h0341, 32'h0000_0000, 1'b0);
        rd(fpb_pkg::LAMP_ADDR, 32'h0000_0002, 1'b1);
        // every size code: line mapping, read back and window edges
        for (int c = 0; c < 4; c++) begin
            wr(fpb_pkg::PAGE_SIZE_ADDR, 32'(c));
            wr(fpb_pkg::PAGE_SELECT_ADDR, 32'h0000_00A5);
            rd(fpb_pkg::PAGE_SELECT_ADDR, 32'h0000_00A5, 1'b1);
            rd(fpb_pkg::PAGE_SIZE_ADDR, 32'(c), 1'b1);
            idle();
            m = {1'b0, sel_mask[c]} << sel_shift[c];
            chk({23'h0, flash_hi_addr & m}, {23'h0, ({1'b0, 8'hA5} << sel_shift[c]) & m});
            mchk(win_base[c], 1'b1);
            mchk(win_base[c] - 20'h00001, 1'b0);
            mchk(fpb_pkg::WIN_END, 1'b1);
            mchk(fpb_pkg::WIN_END + 20'h00001, 1'b0);
        end
        // onboard window edges, with size code 3 still set
        mchk(fpb_pkg::ONB_BASE, 1'b0);
        mchk(fpb_pkg::ONB_END, 1'b0);
        mchk(fpb_pkg::ONB_BASE - 20'h00001, 1'b0);
        // port steering: all rear, then a mixed pattern
        wr(gout_addr, 32'h6000_0000);
        idle();
        outs(5'h00);
        wr(gout_addr, 32'h2800_0000);
        rd(gout_addr, 32'h2800_0000, 1'b1);
        idle();
        outs(5'h09);
        // a moved power management base moves the general output register
        power_mgmt_io_base = 16'h0400;
        rd(16'h0434, 32'h2800_0000, 1'b1);
        rd(16'h1034, 32'h0000_0000, 1'b0);
        // second reset in mid-run
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        reset_vals();
        final_report();
    end
endmodule : tb
